// [trc_map.vh]
// Purpose: Register offsets, field positions and reset values of the trace unit.
// Assumes: Byte addresses on an 8-bit register port, one 32-bit word each.
// Notes:   Definitions only.
`ifndef TRC_MAP_VH
`define TRC_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TRC_RUN_OFS      8'h00
`define TRC_PTACT_OFS    8'h04
`define TRC_SELECT_OFS   8'h08
`define TRC_TIME_OFS     8'h0c
`define TRC_CTL_BASE     8'h10
`define TRC_TGT_BASE     8'h30
`define TRC_RADDR_OFS    8'h50
`define TRC_RDATA_OFS    8'h54
`define TRC_WADDR_OFS    8'h58
`define TRC_WDATA_OFS    8'h5c
`define TRC_STATUS_OFS   8'h60

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TRC_CTL_MODE_LO  0
`define TRC_CTL_CSRC     2
`define TRC_CTL_CCLR     3
`define TRC_CTL_TRACE    4
`define TRC_SEL_IND4     4
`define TRC_TIME_EN      0
`define TRC_TIME_INT_LO  4
`define TRC_TIME_BIT_LO  8

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define TRC_MODE_ALL     2'h0
`define TRC_MODE_SIG     2'h1
`define TRC_MODE_CNT     2'h2
`define TRC_TYPE_DATA    2'h1
`define TRC_TYPE_TS      2'h2
`define TRC_TS_WIDTH     64
`define TRC_FREE_WIDTH   16
`define TRC_INT_BASE     4
`define TRC_REG_RESET    32'h00000000

`endif

// [trc_capture.v]
// Purpose: Trace control and capture into a circular trace memory, with
//          timestamp insertion and register access to the memory.
// Assumes: Trigger logic supplies state entries, matches and group data.
// Notes:   Register port answers reads one cycle after the strobe.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`include "trc_map.vh"

module trc_capture #(
  parameter GW = 64,  // Observed group width, 64 or 128.
  parameter AW = 8    // Trace memory address bits.
) (
  input  wire          i_clk_sys,
  input  wire          i_rst_n,
  input  wire [7:0]    i_addr,
  input  wire [31:0]   i_wdata,
  input  wire          i_wr,
  input  wire          i_rd,
  output reg  [31:0]   o_rdata,
  input  wire          i_state_enter,
  input  wire [2:0]    i_next_state,
  input  wire          i_final,
  input  wire [4:0]    i_sig_match,
  input  wire [GW-1:0] i_group_data,
  input  wire [GW-1:0] i_group4_data,
  input  wire [63:0]   i_ts_value,
  output reg           o_trace_active,
  output reg  [2:0]    o_cur_state
);

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam W     = GW + 8;       // Memory word width.
  localparam NCH   = GW / 32;      // Payload chunks per word.
  localparam DEPTH = 1 << AW;      // Memory depth.

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [W-1:0]  mem [0:DEPTH-1];   // Trace memory.
  reg           run;               // Run bit.
  reg           ptrace;            // Pretrigger trace bit.
  reg           ind4;              // Independent state 4 enable.
  reg  [31:0]   tctl;              // Timestamp control.
  reg  [4:0]    ctl [0:4];         // State trigger controls.
  reg  [15:0]   tgt [0:4];         // State count targets.
  reg  [AW-1:0] cap_addr;          // Capture write address.
  reg  [AW-1:0] rd_addr;           // Host read address.
  reg  [AW-1:0] wr_addr;           // Host write address.
  reg  [W-1:0]  hold;              // Shared holding register.
  reg  [2:0]    rd_idx;            // Next read chunk, 0 is header.
  reg  [2:0]    wr_idx;            // Next write chunk, 0 is header.
  reg  [15:0]   free_cnt;          // Free running cycle counter.
  reg  [19:0]   int_cnt;           // Timestamp interval counter.
  reg           ts_req;            // Pending interval timestamp.
  reg           stop_ts;           // Pending stop timestamp.
  reg           last_data;         // Previous write held data.
  reg           final_seen;        // Trigger sequence ended.
  reg  [15:0]   cnt [0:1];         // Counters: 0 main, 1 state 4.
  integer       k;                 // Loop index of the control registers.
  integer       m;                 // Loop index of the read mux.

  // ----------------------------------------------------------------
  // Decode and state 4 selection
  // ----------------------------------------------------------------
  wire       wr_hit  = i_wr;
  wire [4:0] mctl    = ctl[o_cur_state];
  wire       st4_on  = run & ind4 & ~final_seen;
  // In independent mode state 4 is never a destination.
  wire       enter_ok = i_state_enter & run &
                        ~(ind4 & (i_next_state == 3'h4));
  wire [1:0] src_match;
  wire [1:0] cnt_match;
  wire [1:0] want;
  wire [4:0] uctl [0:1];
  wire [15:0] utgt [0:1];
  assign uctl[0] = mctl;
  assign uctl[1] = ctl[4];
  assign utgt[0] = tgt[o_cur_state];
  assign utgt[1] = tgt[4];
  assign src_match[0] = i_sig_match[o_cur_state];
  assign src_match[1] = i_sig_match[4];

  // ----------------------------------------------------------------
  // Counters and capture requests, one per tracer
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_trc
      wire act = (g == 0) ? (o_trace_active & ~final_seen) :
                            (st4_on & uctl[g][`TRC_CTL_TRACE]);
      wire inc = uctl[g][`TRC_CTL_CSRC] ? src_match[g] : 1'b1;
      assign cnt_match[g] = act & (cnt[g] == utgt[g]);
      // Mode chooses every cycle, signal match or counter.
      assign want[g] = act &
        ((uctl[g][1:0] == `TRC_MODE_ALL) |
         ((uctl[g][1:0] == `TRC_MODE_SIG) & src_match[g]) |
         ((uctl[g][1:0] == `TRC_MODE_CNT) & cnt_match[g]));
      // Main counter restarts on entry; clear takes the cycle after match.
      always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          cnt[g] <= 16'h0000;
        end else if (!act || (g == 0 && enter_ok)) begin
          cnt[g] <= 16'h0000;
        end else if (cnt_match[g]) begin
          if (uctl[g][`TRC_CTL_CCLR]) begin
            cnt[g] <= 16'h0000;
          end
        end else if (inc) begin
          cnt[g] <= cnt[g] + 16'h0001;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Timestamp scheduling
  // ----------------------------------------------------------------
  wire [3:0]  tsint    = tctl[`TRC_TIME_INT_LO +: 4];
  wire [2:0]  bsel     = tctl[`TRC_TIME_BIT_LO +: 3];
  wire [19:0] int_len  = 20'h00001 << (tsint + `TRC_INT_BASE);
  // Interval select zero keeps stamping while running.
  wire        ts_live  = tctl[`TRC_TIME_EN] &
                         (o_trace_active | (run & tsint == 4'h0));
  wire        any_data = want[0] | want[1];
  wire        ts_wr    = ~any_data & (ts_req | stop_ts);
  wire        run_fall = run & wr_hit & (i_addr == `TRC_RUN_OFS) &
                         ~i_wdata[0];

  // Interval counter raises a request; a free cycle consumes it.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      int_cnt <= 20'h00000;
      ts_req  <= 1'b0;
      stop_ts <= 1'b0;
    end else begin
      if (!ts_live) begin
        int_cnt <= 20'h00000;
      end else if (int_cnt >= int_len - 20'h00001) begin
        int_cnt <= 20'h00000;
      end else begin
        int_cnt <= int_cnt + 20'h00001;
      end
      // A new request wins over the one being served.
      if (ts_live && int_cnt >= int_len - 20'h00001) begin
        ts_req <= 1'b1;
      end else if (ts_wr) begin
        ts_req <= 1'b0;
      end
      // Stopping after a data word leaves one timestamp.
      if (run_fall && last_data) begin
        stop_ts <= 1'b1;
      end else if (ts_wr) begin
        stop_ts <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trace word assembly
  // ----------------------------------------------------------------
  wire [1:0] tbits = free_cnt[{bsel, 1'b0} +: 2];
  wire       ovr   = want[1] & want[0];
  wire [2:0] hstate = want[1] ? 3'h4 : o_cur_state;
  wire [1:0] htype = any_data ? `TRC_TYPE_DATA : `TRC_TYPE_TS;
  wire [7:0] header = {tbits, ovr, hstate, htype};
  wire [GW-1:0] ts_pay = {{(GW-64){1'b0}}, i_ts_value};
  // State 4 data takes priority over the main tracer.
  wire [GW-1:0] pay = want[1] ? i_group4_data :
                      (want[0] ? i_group_data : ts_pay);
  wire       cap_we = any_data | ts_wr;

  // ----------------------------------------------------------------
  // Run control, trace-active and trigger state
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_trace_active <= 1'b0;
      o_cur_state    <= 3'h0;
      final_seen     <= 1'b0;
      free_cnt       <= 16'h0000;
      last_data      <= 1'b0;
    end else begin
      free_cnt <= free_cnt + 16'h0001;
      if (cap_we) begin
        last_data <= any_data;
      end
      if (wr_hit && i_addr == `TRC_RUN_OFS) begin
        if (i_wdata[0] && !run) begin
          o_trace_active <= ptrace;
          o_cur_state    <= 3'h0;
          final_seen     <= 1'b0;
        end else if (!i_wdata[0]) begin
          o_trace_active <= 1'b0;
        end
      end else if (i_final && run) begin
        final_seen     <= 1'b1;
        o_trace_active <= 1'b0;
      end else if (enter_ok) begin
        o_cur_state    <= i_next_state;
        o_trace_active <= ctl[i_next_state][`TRC_CTL_TRACE];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      run    <= 1'b0;
      ptrace <= 1'b0;
      ind4   <= 1'b0;
      tctl   <= `TRC_REG_RESET;
      for (k = 0; k < 5; k = k + 1) begin
        ctl[k] <= 5'h00;
        tgt[k] <= 16'h0000;
      end
    end else if (wr_hit) begin
      if (i_addr == `TRC_RUN_OFS) begin
        run <= i_wdata[0];
      end
      if (i_addr == `TRC_PTACT_OFS) begin
        ptrace <= i_wdata[0];
      end
      if (i_addr == `TRC_SELECT_OFS) begin
        ind4 <= i_wdata[`TRC_SEL_IND4];
      end
      if (i_addr == `TRC_TIME_OFS) begin
        tctl <= i_wdata;
      end
      for (k = 0; k < 5; k = k + 1) begin
        if (i_addr == `TRC_CTL_BASE + 4 * k) begin
          ctl[k] <= i_wdata[4:0];
        end
        if (i_addr == `TRC_TGT_BASE + 4 * k) begin
          tgt[k] <= i_wdata[15:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Host access to the memory through the holding register
  // ----------------------------------------------------------------
  wire rd_pay  = i_rd & (i_addr == `TRC_RDATA_OFS);
  wire rd_last = rd_pay & (rd_idx == NCH);
  wire wd_hit  = wr_hit & (i_addr == `TRC_WDATA_OFS);
  wire wd_last = wd_hit & (wr_idx == NCH);
  wire [AW-1:0] rd_nxt = rd_addr + {{(AW-1){1'b0}}, 1'b1};
  wire [W-1:0]  wd_word = {i_wdata, hold[W-33:0]};

  // Address and chunk tracking for both directions.
  // Host and capture share one clock, so no handshake is needed.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rd_addr <= {AW{1'b0}};
      wr_addr <= {AW{1'b0}};
      rd_idx  <= 3'h0;
      wr_idx  <= 3'h0;
      hold    <= {W{1'b0}};
    end else begin
      if (wr_hit && i_addr == `TRC_RADDR_OFS) begin
        rd_addr <= i_wdata[AW-1:0];
        rd_idx  <= 3'h0;
        hold    <= mem[i_wdata[AW-1:0]];
      end else if (rd_last) begin
        rd_addr <= rd_nxt;
        rd_idx  <= 3'h0;
        hold    <= mem[rd_nxt];
      end else if (rd_pay) begin
        rd_idx <= rd_idx + 3'h1;
      end
      if (wr_hit && i_addr == `TRC_WADDR_OFS) begin
        wr_addr <= i_wdata[AW-1:0];
        wr_idx  <= 3'h0;
      end else if (wd_last) begin
        wr_addr <= wr_addr + {{(AW-1){1'b0}}, 1'b1};
        wr_idx  <= 3'h0;
      end else if (wd_hit) begin
        wr_idx <= wr_idx + 3'h1;
        if (wr_idx == 3'h0) begin
          hold[7:0] <= i_wdata[7:0];
        end else begin
          hold[8 + 32 * (wr_idx - 3'h1) +: 32] <= i_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory write port and capture address
  // ----------------------------------------------------------------
  // Capture has priority; a host write lands only in a cycle without a capture write.
  always @(posedge i_clk_sys) begin
    if (cap_we) begin
      mem[cap_addr] <= {pay, header};
    end else if (wd_last) begin
      mem[wr_addr] <= wd_word;
    end
  end

  // Capture address runs as a circular pointer.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cap_addr <= {AW{1'b0}};
    end else if (cap_we) begin
      cap_addr <= cap_addr + {{(AW-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `TRC_RUN_OFS:    o_rdata <= {31'h0, run};
        `TRC_PTACT_OFS:  o_rdata <= {31'h0, ptrace};
        `TRC_SELECT_OFS: o_rdata <= {27'h0, ind4, 4'h0};
        `TRC_TIME_OFS:   o_rdata <= tctl;
        `TRC_RADDR_OFS:  o_rdata <= {{(32-AW){1'b0}}, rd_addr};
        `TRC_WADDR_OFS:  o_rdata <= {{(32-AW){1'b0}}, wr_addr};
        `TRC_STATUS_OFS: o_rdata <= {27'h0, final_seen, o_trace_active,
                                     o_cur_state};
        `TRC_RDATA_OFS: begin
          if (rd_idx == 3'h0) begin
            o_rdata <= {24'h0, hold[7:0]};
          end else begin
            o_rdata <= hold[8 + 32 * (rd_idx - 3'h1) +: 32];
          end
        end
        default: begin
          o_rdata <= 32'h00000000;
          for (m = 0; m < 5; m = m + 1) begin
            if (i_addr == `TRC_CTL_BASE + 4 * m) begin
              o_rdata <= {27'h0, ctl[m]};
            end
            if (i_addr == `TRC_TGT_BASE + 4 * m) begin
              o_rdata <= {16'h0, tgt[m]};
            end
          end
        end
      endcase
    end
  end

endmodule

// [tcsu_monitor.sv]
// Purpose: Port-level checker for the trace capture unit.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Shadows run, pretrigger, select and trace bits from host writes.
`timescale 1ns/100ps
module tcsu_monitor (
  input wire        i_clk_sys,
  input wire        i_rst_n,
  input wire [7:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  input wire        i_state_enter,
  input wire [2:0]  i_next_state,
  input wire        i_final,
  input wire        o_trace_active,
  input wire [2:0]  o_cur_state
);
  reg       run_q;                    // Shadow of the run bit.
  reg       pt_q;                     // Shadow of the pretrigger trace bit.
  reg       ind_q;                    // Shadow of the independent state 4 bit.
  reg [4:0] tr_q;                     // Shadow of each state's trace bit.
  wire      tr_nxt = tr_q[i_next_state];  // Trace bit of the state entered.

  // ---------------------------------------------------------------
  // Shadow registers
  // ---------------------------------------------------------------
  // Follows host writes so expectations never look inside the design.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
      pt_q  <= 1'b0;
      ind_q <= 1'b0;
      tr_q  <= 5'h00;
    end else if (i_wr) begin
      case (i_addr)
        8'h00: run_q <= i_wdata[0];
        8'h04: pt_q <= i_wdata[0];
        8'h08: ind_q <= i_wdata[4];
        8'h10: tr_q[0] <= i_wdata[4];
        8'h14: tr_q[1] <= i_wdata[4];
        8'h18: tr_q[2] <= i_wdata[4];
        8'h1c: tr_q[3] <= i_wdata[4];
        8'h20: tr_q[4] <= i_wdata[4];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  AST_RUN_START: assert property (i_wr && i_addr == 8'h00 && i_wdata[0] && !run_q
    && !i_state_enter |=> o_trace_active == pt_q && o_cur_state == 3'h0)
    else $error("run start did not load the pretrigger trace state");
  AST_RUN_GATE: assert property (!run_q |-> !o_trace_active)
    else $error("trace active while stopped");
  AST_STEP: assert property (run_q && i_state_enter && !i_final && !i_wr
    && !(ind_q && i_next_state == 3'h4)
    |=> o_cur_state == $past(i_next_state) && o_trace_active == $past(tr_nxt))
    else $error("state entry did not follow the entered state");
  AST_IND: assert property (run_q && ind_q && i_state_enter && i_next_state == 3'h4
    && !i_wr |=> $stable(o_cur_state))
    else $error("independent state 4 was entered");
  AST_FINAL: assert property (run_q && i_final && !i_wr |=> !o_trace_active[*2])
    else $error("trace still active after final state");
  AST_RD_HOLD: assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data changed without a read");
  AST_RD_UNMAP: assert property (i_rd && i_addr >= 8'h64 |=> o_rdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  AST_STATUS: assert property (i_rd && i_addr == 8'h60
    |=> o_rdata[3:0] == {$past(o_trace_active), $past(o_cur_state)})
    else $error("status read disagrees with state outputs");
endmodule

bind trc_capture tcsu_monitor u_mon (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_state_enter(i_state_enter),
  .i_next_state(i_next_state), .i_final(i_final),
  .o_trace_active(o_trace_active), .o_cur_state(o_cur_state));

// [tcsu_source.sv]
// Purpose: Observed-signal and timestamp source facing the capture unit.
// Assumes: Same clock as the unit, 64-bit groups.
// Notes:   Each stream carries a counter so a stored word names its cycle.
`timescale 1ns/100ps
module tcsu_source (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  output wire [63:0] o_group,
  output wire [63:0] o_group4,
  output wire [63:0] o_ts
);
  reg [31:0] cnt;  // Free-running sample counter.

  // Advances every cycle, like a real observed bus.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt <= 32'h0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  // Distinct patterns let the reader tell the three payload kinds apart.
  assign o_group  = {~cnt, cnt};
  assign o_group4 = {cnt, cnt ^ 32'h5a5a5a5a};
  assign o_ts     = {cnt, cnt};  // 32-bit sample count repeated in both halves.
endmodule

// [trace_capture_sram_unit_tb.sv]
// Purpose: Self-checking bench for the trace capture unit.
// Assumes: Eight-word memory (AW 3) and 64-bit groups.
// Notes:   Memory is zeroed by host writes before each capture run.
`timescale 1ns/100ps
module trace_capture_sram_unit_tb;
  reg         i_clk_sys     = 1'b0;   // Sampling clock.
  reg         i_rst_n       = 1'b0;   // Synchronous reset.
  reg  [7:0]  i_addr        = 8'h00;  // Register address.
  reg  [31:0] i_wdata       = 32'h0;  // Register write data.
  reg         i_wr          = 1'b0;   // Write strobe.
  reg         i_rd          = 1'b0;   // Read strobe.
  reg         i_state_enter = 1'b0;   // State entry pulse.
  reg  [2:0]  i_next_state  = 3'h0;   // State being entered.
  reg         i_final       = 1'b0;   // Final state pulse.
  reg  [4:0]  i_sig_match   = 5'h00;  // Per-state match levels.
  wire [31:0] o_rdata;                // Register read data.
  wire [63:0] grp;                    // Main group data.
  wire [63:0] grp4;                   // State 4 group data.
  wire [63:0] ts;                     // Timestamp.
  wire        o_trace_active;         // Trace active level.
  wire [2:0]  o_cur_state;            // Current trigger state.
  integer     fails         = 0;      // Mismatches seen.
  integer     check_count   = 0;      // Comparisons made.
  integer     k;                      // Loop index.
  reg  [31:0] v;                      // Last read value.

  always #12.5 i_clk_sys = ~i_clk_sys;  // 40 MHz.

  tcsu_source i_src (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .o_group(grp),
    .o_group4(grp4), .o_ts(ts));

  trc_capture #(.GW(64), .AW(3)) i_dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_state_enter(i_state_enter),
    .i_next_state(i_next_state), .i_final(i_final), .i_sig_match(i_sig_match),
    .i_group_data(grp), .i_group4_data(grp4), .i_ts_value(ts),
    .o_trace_active(o_trace_active), .o_cur_state(o_cur_state));

  // Host test pattern: headers carry junk above the low byte.
  function [31:0] pat(input integer n);
    pat = (n % 3 == 0) ? 32'habcdef50 + n : {8{n[3:0]}};
  endfunction

  // Counts and reports one comparison.
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // One-cycle write; the idle cycle after it avoids double assignment.
  task wr(input [7:0] a, input [31:0] d);
    begin
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk_sys);
      i_wr    <= 1'b0;
      @(posedge i_clk_sys);
    end
  endtask

  // One-cycle read; data stands from the following cycle until the next read.
  task rd(input [7:0] a, output [31:0] d);
    begin
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk_sys);
      i_rd   <= 1'b0;
      @(negedge i_clk_sys);
      d = o_rdata;
      @(posedge i_clk_sys);
    end
  endtask

  // Pulses a state entry, or the final state when f is set.
  task enter(input [2:0] n, input f);
    begin
      i_next_state  <= n;
      i_state_enter <= !f;
      i_final       <= f;
      @(posedge i_clk_sys);
      i_state_enter <= 1'b0;
      i_final       <= 1'b0;
      @(posedge i_clk_sys);
    end
  endtask

  // Zeroes memory, programs state 0, state 4, select and time, then runs.
  task start(input [31:0] c0, input [31:0] c4, input [31:0] sel, input [31:0] tim,
             input [31:0] pt);
    begin
      wr(8'h58, 32'h0);
      for (k = 0; k < 24; k = k + 1) wr(8'h5c, 32'h0);
      wr(8'h10, c0);
      wr(8'h20, c4);
      wr(8'h08, sel);
      wr(8'h0c, tim);
      wr(8'h04, pt);
      wr(8'h00, 32'h1);
    end
  endtask

  // Stops, then reads every word and checks kind, header and counts.
  task scan(input [3:0] nd, input [3:0] ntl, input [3:0] nth, input [3:0] st, input ov);
    integer    j;
    integer    n_d;
    integer    n_t;
    reg [31:0] h;
    reg [31:0] c0;
    reg [31:0] c1;
    reg [1:0]  off;
    reg [1:0]  off0;
    begin
      n_d = 0;
      n_t = 0;
      off0 = 2'h0;
      wr(8'h00, 32'h0);
      repeat (4) @(posedge i_clk_sys);
      chk("trace_active", 32'h0, {31'h0, o_trace_active});
      wr(8'h50, 32'h0);
      for (j = 0; j < 8; j = j + 1) begin
        rd(8'h54, h);
        rd(8'h54, c0);
        rd(8'h54, c1);
        if (h[1:0] === 2'h1) begin
          n_d = n_d + 1;
          chk("hdr_state", {28'h0, st}, {29'h0, h[4:2]});
          chk("hdr_ovr", {31'h0, ov}, {31'h0, h[5]});
          chk("payload", (st == 4'h4) ? c0 ^ 32'h5a5a5a5a : ~c0, c1);
          off = h[7:6] - ((st == 4'h4) ? c1[1:0] : c0[1:0]);
          if (n_d == 1) off0 = off;
          chk("hdr_cnt", {30'h0, off0}, {30'h0, off});
        end else if (h[1:0] === 2'h2) begin
          n_t = n_t + 1;
          chk("ts_payload", c0, c1);
        end else begin
          chk("empty_word", 32'h0, h | c0 | c1);
        end
      end
      chk("data_words", {28'h0, nd}, n_d);
      chk("ts_words", 32'h1, {31'h0, n_t >= ntl && n_t <= nth});
    end
  endtask

  // Prints the verdict and ends the run.
  task conclude;
    begin
      if (fails == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fails = fails + 1;
    conclude;
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    wr(8'h30, 32'h5);
    wr(8'h58, 32'h7);
    for (k = 0; k < 6; k = k + 1) wr(8'h5c, pat(k));
    wr(8'h70, 32'hffffffff);
    wr(8'h50, 32'h7);
    for (k = 0; k < 6; k = k + 1) begin
      rd(8'h54, v);
      chk("host_word", (k % 3 == 0) ? pat(k) & 32'hff : pat(k), v);
    end
    rd(8'h64, v);
    chk("unmapped", 32'h0, v);
    start(32'h10, 32'h0, 32'h0, 32'hf1, 32'h1);
    repeat (18) @(posedge i_clk_sys);
    scan(4'h7, 4'h1, 4'h1, 4'h0, 1'b0);
    start(32'h10, 32'h10, 32'h10, 32'hf1, 32'h1);
    enter(3'h4, 1'b0);
    repeat (16) @(posedge i_clk_sys);
    scan(4'h7, 4'h1, 4'h1, 4'h4, 1'b1);
    start(32'h1a, 32'h0, 32'h0, 32'hf1, 32'h1);
    repeat (18) @(posedge i_clk_sys);
    scan(4'h3, 4'h1, 4'h1, 4'h0, 1'b0);
    start(32'h11, 32'h0, 32'h0, 32'h01, 32'h1);
    i_sig_match <= 5'h01;
    repeat (2) @(posedge i_clk_sys);
    i_sig_match <= 5'h02;
    repeat (2) @(posedge i_clk_sys);
    i_sig_match <= 5'h00;
    enter(3'h1, 1'b0);
    repeat (32) @(posedge i_clk_sys);
    scan(4'h2, 4'h2, 4'h2, 4'h0, 1'b0);
    wr(8'h40, 32'h5);
    start(32'h0, 32'h1a, 32'h10, 32'hf1, 32'h0);
    repeat (18) @(posedge i_clk_sys);
    scan(4'h3, 4'h1, 4'h1, 4'h4, 1'b0);
    wr(8'h18, 32'h10);
    wr(8'h1c, 32'h0);
    start(32'h10, 32'h0, 32'h0, 32'hf1, 32'h0);
    rd(8'h60, v);
    chk("status", 32'h00, {27'h0, v[4:0]});
    enter(3'h2, 1'b0);
    rd(8'h60, v);
    chk("status", 32'h0a, {27'h0, v[4:0]});
    enter(3'h3, 1'b0);
    rd(8'h60, v);
    chk("status", 32'h03, {27'h0, v[4:0]});
    enter(3'h0, 1'b1);
    rd(8'h60, v);
    chk("status", 32'h13, {27'h0, v[4:0]});
    wr(8'h00, 32'h0);
    conclude;
  end
endmodule
